// ==== rtl/reset_and_power_fail_control.v ====
// Reset merge, reset stretch, power-fail supervision and flash lock
//
// How it works
// - System reset from pin, watchdog, power-fail or address-fail.
// - Reset clears page select and direct page flag, main clock, clocks off.
// - After release wait 65.5 ms plus 7 periods before executing.
// - Reset never touches data RAM; RAM is undefined after power-up.
// - Release loads program counter from vector at fffe/ffff.
// - Fetch from bad code area or RAM gives address-fail reset if enabled.
// - Power-fail control register holds a detector enable bit.
// - Enabled detector flags failure after supply stays low 100 ns.
// - Action select bit chooses reset or freeze on power fail.
// - Flash parts select threshold by two bits of config byte 703f.
// - Thresholds 2.4, 2.7, 3.0 V; 2.7 V when unprogrammed.
// - 3.0 V threshold on a sub-3 V supply freezes forever.
// - Device config byte 20ff only reachable in flash program mode.
// - Locked part returns 5a on every flash array read.
// - Locked part refuses writes and readback of program area.
`include "rst_pwr_defines.vh"
module reset_and_power_fail_control #(
  parameter [23:0] STRETCH_CYCLES = `STRETCH_CYC,
  parameter FLASH_PART = 1,
  parameter [1:0] MASK_LEVEL = `LVL_DEFAULT
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Reset sources
  input wire reset_pin_b,
  input wire wdt_timeout,
  input wire addr_fail_en,
  // Core fetch monitor
  input wire fetch_valid,
  input wire fetch_bad_region,
  input wire fetch_in_ram,
  // Power-fail control register written by software
  input wire pfc_wr,
  input wire pfc_wr_enable,
  input wire pfc_wr_action,
  // Supply comparators (analog, asynchronous)
  input wire below_2v4,
  input wire below_2v7,
  input wire below_3v0,
  // Configuration byte from flash and mode
  input wire [7:0] cfg_byte,
  input wire prog_mode,
  // Flash access from core or programmer
  input wire flash_rd,
  input wire flash_wr,
  input wire [15:0] flash_addr,
  input wire [7:0] flash_wdata,
  input wire [7:0] flash_rdata,
  // Config byte store
  input wire [7:0] dev_cfg_rdata,
  // System reset and core control
  output wire sys_reset,
  output reg core_run_r,
  output reg core_freeze_r,
  output reg [15:0] vec_fetch_addr_r,
  output reg vec_fetch_r,
  output reg ram_page_select_r,
  output reg direct_page_flag_r,
  output reg main_clk_sel_r,
  output reg periph_clk_en_r,
  output reg wdt_enable_clr_r,
  output reg power_fail_detect_enable,
  output reg power_fail_action_select,
  output reg power_fail_flag_r,
  output reg [1:0] fail_level_r,
  // Flash gating
  output reg [7:0] data_port_r,
  output reg flash_wr_ok_r,
  output reg dev_cfg_wr_r,
  output reg [7:0] dev_cfg_wdata_r
);
  localparam S_RESET = 3'b001;
  localparam S_STRETCH = 3'b010;
  localparam S_RUN = 3'b100;

  reg pin_s1_r, pin_s2_r;
  reg [2:0] cmp1_r, cmp2_r;
  reg addr_fail_r;
  reg pf_reset_r;
  reg [2:0] state_r, state_nxt;
  reg [3:0] filt_r;
  wire stretch_done;
  wire below_sel;
  wire locked;
  wire fail_level_select_lo;
  wire fail_level_select_hi;
  wire freeze_nxt;

  // Pin and comparators are asynchronous: two flops each
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      cmp1_r <= 3'h0;
      cmp2_r <= 3'h0;
    end else begin
      pin_s1_r <= reset_pin_b;
      pin_s2_r <= pin_s1_r;
      cmp1_r <= {below_3v0, below_2v7, below_2v4};
      cmp2_r <= cmp1_r;
    end
  end

  // Merged reset request; pin held low 8 periods is seen by the sync
  assign sys_reset = !pin_s2_r || wdt_timeout || addr_fail_r
                     || pf_reset_r;

  // Address-fail detection, registered into the reset merge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_fail_r <= 1'b0;
    end else begin
      addr_fail_r <= addr_fail_en && fetch_valid && core_run_r
                     && (fetch_bad_region || fetch_in_ram);
    end
  end

  // Threshold selection
  assign fail_level_select_lo = cfg_byte[`LVL_SEL_LO_BIT];
  assign fail_level_select_hi = cfg_byte[`LVL_SEL_HI_BIT];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fail_level_r <= `LVL_DEFAULT;
    end else if (FLASH_PART != 0) begin
      fail_level_r <= {fail_level_select_hi, fail_level_select_lo};
    end else begin
      fail_level_r <= MASK_LEVEL;
    end
  end

  // Unused code 2'h3 falls back to the default 2.7 V
  assign below_sel = (fail_level_r == `LVL_2V4) ? cmp2_r[0] :
                     (fail_level_r == `LVL_3V0) ? cmp2_r[2] :
                     cmp2_r[1];

  // Power-fail control register, cleared by any reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_fail_detect_enable <= 1'b0;
      power_fail_action_select <= 1'b0;
    end else if (sys_reset) begin
      power_fail_detect_enable <= 1'b0;
      power_fail_action_select <= 1'b0;
    end else if (pfc_wr) begin
      power_fail_detect_enable <= pfc_wr_enable;
      power_fail_action_select <= pfc_wr_action;
    end
  end

  // Low supply must persist the filter time; then flag follows supply
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_r <= 4'h0;
      power_fail_flag_r <= 1'b0;
    end else if (!power_fail_detect_enable || !below_sel) begin
      filt_r <= 4'h0;
      power_fail_flag_r <= 1'b0;
    end else if (filt_r < `PF_FILTER_CYC) begin
      filt_r <= filt_r + 4'h1;
    end else begin
      power_fail_flag_r <= 1'b1;
    end
  end

  // Action select 0 resets, 1 freezes; a reset request overrides freeze
  assign freeze_nxt = power_fail_flag_r && power_fail_action_select
                      && !sys_reset;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_reset_r <= 1'b0;
      core_freeze_r <= 1'b0;
    end else begin
      pf_reset_r <= power_fail_flag_r && !power_fail_action_select
                    && !pf_reset_r;
      core_freeze_r <= freeze_nxt;
    end
  end

  // Reset sequencer
  stretch_counter #(
    .COUNT(STRETCH_CYCLES)
  ) u_stretch (
    .clk(clk),
    .rst_b(rst_b),
    .restart(sys_reset || state_r == S_RESET),
    .done_r(stretch_done)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_RESET: begin
        if (!sys_reset) begin
          state_nxt = S_STRETCH;
        end
      end
      S_STRETCH: begin
        if (sys_reset) begin
          state_nxt = S_RESET;
        end else if (stretch_done) begin
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        if (sys_reset) begin
          state_nxt = S_RESET;
        end
      end
      default: begin
        state_nxt = S_RESET;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Core state initialisation; RAM has no reset path here
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_page_select_r <= 1'b0;
      direct_page_flag_r <= 1'b0;
      main_clk_sel_r <= 1'b1;
      periph_clk_en_r <= 1'b0;
      wdt_enable_clr_r <= 1'b1;
    end else begin
      // data RAM is left alone by every reset source
      if (sys_reset || state_r == S_RESET) begin
        ram_page_select_r <= 1'b0;
        direct_page_flag_r <= 1'b0;
        main_clk_sel_r <= 1'b1;
        periph_clk_en_r <= 1'b0;
      end
      wdt_enable_clr_r <= sys_reset || (state_r == S_RESET);
    end
  end

  // First fetches read the reset vector, low then high byte
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_run_r <= 1'b0;
      vec_fetch_r <= 1'b0;
      vec_fetch_addr_r <= `VEC_LO_ADDR;
    end else begin
      // Run drops on the same edge that raises freeze
      core_run_r <= (state_nxt == S_RUN) && !freeze_nxt;
      if (state_r == S_STRETCH && state_nxt == S_RUN) begin
        vec_fetch_r <= 1'b1;
        vec_fetch_addr_r <= `VEC_LO_ADDR;
      end else if (vec_fetch_r
                   && vec_fetch_addr_r == `VEC_LO_ADDR) begin
        vec_fetch_addr_r <= `VEC_HI_ADDR;
      end else begin
        vec_fetch_r <= 1'b0;
        vec_fetch_addr_r <= `VEC_LO_ADDR;
      end
    end
  end

  // Flash lock and configuration area gating
  assign locked = cfg_byte[`LOCK_BIT];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_port_r <= 8'h00;
      flash_wr_ok_r <= 1'b0;
      dev_cfg_wr_r <= 1'b0;
      dev_cfg_wdata_r <= 8'h00;
    end else begin
      dev_cfg_wr_r <= 1'b0;
      flash_wr_ok_r <= 1'b0;
      if (flash_addr == `DEV_CFG_ADDR) begin
        if (prog_mode) begin
          if (flash_rd) begin
            data_port_r <= dev_cfg_rdata;
          end
          dev_cfg_wr_r <= flash_wr;
          dev_cfg_wdata_r <= flash_wdata;
        end else if (flash_rd) begin
          data_port_r <= 8'h00;
        end
      end else begin
        if (flash_rd) begin
          data_port_r <= locked ? `LOCK_READ_DATA : flash_rdata;
        end
        flash_wr_ok_r <= flash_wr && !locked;
      end
    end
  end
endmodule

// ==== rtl/rst_pwr_defines.vh ====
// Constants for the reset and power-fail supervisor
`ifndef RST_PWR_DEFINES_VH
`define RST_PWR_DEFINES_VH
`define CLK_HZ 10000000
`define CLK_NS 100
// Extended reset wait, printed 65.5 ms, held in microseconds
`define STRETCH_US 65500
`define STRETCH_CYC ((`STRETCH_US * (`CLK_HZ / 1000000)) + 7)
`define EXTRA_OSC 7
`define PIN_MIN_OSC 8
`define PF_FILTER_NS 100
`define PF_FILTER_CYC ((`PF_FILTER_NS + `CLK_NS - 1) / `CLK_NS)
`define VEC_LO_ADDR 16'hfffe
`define VEC_HI_ADDR 16'hffff
`define CFG_FLASH_ADDR 16'h703f
`define DEV_CFG_ADDR 16'h20ff
`define LOCK_READ_DATA 8'h5a
`define LVL_2V4 2'h1
`define LVL_2V7 2'h0
`define LVL_3V0 2'h2
`define LVL_DEFAULT 2'h0
`define LVL_SEL_LO_BIT 0
`define LVL_SEL_HI_BIT 1
`define LOCK_BIT 7
`endif

// ==== rtl/stretch_counter.v ====
// Reset-stretch counter running on the oscillator clock
module stretch_counter #(
  parameter [23:0] COUNT = 24'd655007
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire restart,
  output reg done_r
);
  reg [23:0] cnt_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 24'h000000;
      done_r <= 1'b0;
    end else if (restart) begin
      cnt_r <= 24'h000000;
      done_r <= 1'b0;
    end else if (!done_r) begin
      if (cnt_r == COUNT - 24'd1) begin
        done_r <= 1'b1;
      end
      cnt_r <= cnt_r + 24'd1;
    end
  end
endmodule

// ==== testbench/rst_pwr_props.sv ====
// Port checker for the reset and power-fail controller
module rst_pwr_props #(
  parameter [23:0] STRETCH_CYCLES = 24'h14
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Inputs
  input wire wdt_timeout,
  input wire addr_fail_en,
  input wire fetch_valid,
  input wire fetch_bad_region,
  input wire fetch_in_ram,
  input wire prog_mode,
  input wire flash_rd,
  input wire flash_wr,
  input wire [15:0] flash_addr,
  input wire [7:0] cfg_byte,
  // Outputs
  input wire sys_reset,
  input wire core_run_r,
  input wire core_freeze_r,
  input wire [15:0] vec_fetch_addr_r,
  input wire vec_fetch_r,
  input wire ram_page_select_r,
  input wire direct_page_flag_r,
  input wire main_clk_sel_r,
  input wire periph_clk_en_r,
  input wire power_fail_detect_enable,
  input wire power_fail_action_select,
  input wire [7:0] data_port_r,
  input wire flash_wr_ok_r
);
  logic [23:0] cnt_r;
  logic str_r;
  // Counts stretch cycles since the merged reset went away
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 24'h0;
      str_r <= 1'b0;
    end else if (sys_reset) begin
      cnt_r <= 24'h0;
      str_r <= 1'b1;
    end else if (core_run_r) begin
      str_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 24'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence vec_lo; vec_fetch_r && vec_fetch_addr_r == 16'hfffe; endsequence
  sequence vec_hi; vec_fetch_r && vec_fetch_addr_r == 16'hffff; endsequence
  AST_INIT_STATE: assert property (
    sys_reset |=> !ram_page_select_r && !direct_page_flag_r
      && main_clk_sel_r && !periph_clk_en_r) else $error("bad reset state");
  AST_INIT_STOP: assert property (
    sys_reset |=> !core_run_r && !power_fail_detect_enable)
    else $error("core or detector left on in reset");
  AST_WDT: assert property (wdt_timeout |-> ##[0:2] sys_reset)
    else $error("watchdog gave no reset");
  AST_ADDR_FAIL: assert property (
    addr_fail_en && fetch_valid && (fetch_bad_region || fetch_in_ram)
      |-> ##[0:2] sys_reset) else $error("no address-fail reset");
  AST_VECTOR: assert property (
    $rose(vec_fetch_r) |-> vec_lo ##1 vec_hi ##1 !vec_fetch_r)
    else $error("vector fetch order wrong");
  AST_RUN_VEC: assert property ($rose(core_run_r) && str_r |-> vec_lo)
    else $error("start without vector fetch");
  AST_STRETCH: assert property ($rose(core_run_r) && str_r |->
    cnt_r >= STRETCH_CYCLES - 1 && cnt_r <= STRETCH_CYCLES + 4)
    else $error("stretch length wrong");
  AST_LOCK_RD: assert property (
    flash_rd && cfg_byte[7] && flash_addr != 16'h20ff
      |=> data_port_r == 8'h5a) else $error("locked read leaked");
  AST_LOCK_WR: assert property (flash_wr && cfg_byte[7] |=> !flash_wr_ok_r)
    else $error("locked write accepted");
  AST_CFG_HIDE: assert property (
    flash_rd && !prog_mode && flash_addr == 16'h20ff |=> data_port_r == 8'h0)
    else $error("config byte visible");
  AST_FREEZE: assert property (
    core_freeze_r |-> !core_run_r && power_fail_action_select)
    else $error("freeze state wrong");
endmodule

// ==== testbench/ext_reset_model.sv ====
// External reset circuit pulling the reset pin low
module ext_reset_model (
  // Clock
  input wire logic clk,
  // Request
  input wire logic go,
  // Pin
  output logic reset_pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  always @(posedge clk) begin
    if (go) n <= 8;
    else if (n != 0) n <= n - 1;
    reset_pin_b <= !(go || n > 1);
  end
endmodule

// ==== testbench/reset_and_power_fail_control_tb.sv ====
// Bench for the reset and power-fail controller
module reset_and_power_fail_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] S = 24'h14;
  logic clk, rst_b, reset_pin_b, wdt_timeout, addr_fail_en, fetch_valid;
  logic fetch_bad_region, fetch_in_ram, pfc_wr, pfc_wr_enable, pfc_wr_action;
  logic below_2v7, prog_mode, flash_rd, flash_wr, pin_go, sys_reset;
  logic core_run_r, core_freeze_r, vec_fetch_r, ram_page_select_r;
  logic direct_page_flag_r, main_clk_sel_r, periph_clk_en_r, wdt_enable_clr_r;
  logic power_fail_detect_enable, power_fail_action_select, power_fail_flag_r;
  logic flash_wr_ok_r, dev_cfg_wr_r, below_2v4, below_3v0;
  logic [1:0] fail_level_r;
  logic [7:0] cfg_byte, flash_wdata, flash_rdata, data_port_r, dev_cfg_wdata_r;
  logic [15:0] flash_addr, vec_fetch_addr_r;
  int num_errors = 0;
  int compares = 0;
  int n;
  reset_and_power_fail_control #(.STRETCH_CYCLES(S)) DUT (.clk, .rst_b,
    .reset_pin_b, .wdt_timeout, .addr_fail_en, .fetch_valid, .fetch_bad_region,
    .fetch_in_ram, .pfc_wr, .pfc_wr_enable, .pfc_wr_action, .below_2v4,
    .below_2v7, .below_3v0, .cfg_byte, .prog_mode, .flash_rd, .flash_wr,
    .flash_addr, .flash_wdata, .flash_rdata, .dev_cfg_rdata(8'h3c), .sys_reset,
    .core_run_r, .core_freeze_r, .vec_fetch_addr_r, .vec_fetch_r,
    .ram_page_select_r, .direct_page_flag_r, .main_clk_sel_r, .periph_clk_en_r,
    .wdt_enable_clr_r, .power_fail_detect_enable, .power_fail_action_select,
    .power_fail_flag_r, .fail_level_r, .data_port_r, .flash_wr_ok_r,
    .dev_cfg_wr_r, .dev_cfg_wdata_r);
  ext_reset_model pin_drv (.clk, .go(pin_go), .reset_pin_b);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Sees a reset, then measures the stretch and the vector fetch
  task automatic boot;
    n = 0;
    while (sys_reset !== 1'b1 && n < 10) begin
      @(posedge clk) #1;
      n++;
    end
    chk(sys_reset, 1'b1);
    while (sys_reset === 1'b1) @(posedge clk) #1;
    n = 0;
    while (core_run_r !== 1'b1 && n < 100) begin
      @(posedge clk) #1;
      n++;
    end
    chk(n >= S - 1 && n <= S + 4, 1'b1);
    chk({vec_fetch_r, vec_fetch_addr_r}, 17'h1fffe);
    @(posedge clk) #1;
    chk({vec_fetch_r, vec_fetch_addr_r}, 17'h1ffff);
  endtask
  task automatic fop(input logic rd, input logic wr, input logic [15:0] a);
    @(posedge clk);
    flash_rd <= rd;
    flash_wr <= wr;
    flash_addr <= a;
    @(posedge clk);
    flash_rd <= 1'b0;
    flash_wr <= 1'b0;
    #1;
  endtask
  task automatic pfc(input logic en, input logic act);
    @(posedge clk);
    pfc_wr <= 1'b1;
    pfc_wr_enable <= en;
    pfc_wr_action <= act;
    @(posedge clk);
    pfc_wr <= 1'b0;
  endtask
  initial begin
    {rst_b, wdt_timeout, addr_fail_en, fetch_valid, fetch_bad_region} <= 5'h0;
    {fetch_in_ram, pfc_wr, pfc_wr_enable, pfc_wr_action} <= 4'h0;
    {below_2v7, prog_mode, flash_rd, flash_wr, pin_go} <= 5'h0;
    {below_2v4, below_3v0} <= 2'h0;
    cfg_byte <= 8'h00;
    flash_wdata <= 8'h96;
    flash_rdata <= 8'ha5;
    flash_addr <= 16'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    boot;
    chk({ram_page_select_r, direct_page_flag_r, main_clk_sel_r,
      periph_clk_en_r, power_fail_detect_enable, fail_level_r}, 7'h10);
    $display("power-on test done");
    @(posedge clk);
    pin_go <= 1'b1;
    @(posedge clk);
    pin_go <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({sys_reset, wdt_enable_clr_r, periph_clk_en_r}, 3'h6);
    boot;
    $display("pin reset test done");
    @(posedge clk);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    boot;
    $display("watchdog test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {fetch_valid, fetch_in_ram, fetch_bad_region} <= {1'b1, k == 0, k == 1};
      repeat (4) @(posedge clk);
      #1 chk(core_run_r, 1'b1);
      @(posedge clk);
      addr_fail_en <= 1'b1;
      @(posedge clk);
      {addr_fail_en, fetch_valid} <= 2'h0;
      #1 boot;
    end
    $display("address-fail test done");
    fop(1'b1, 1'b0, 16'h1234); chk(data_port_r, 8'ha5);
    fop(1'b0, 1'b1, 16'h1234); chk(flash_wr_ok_r, 1'b1);
    fop(1'b1, 1'b0, 16'h20ff); chk(data_port_r, 8'h00);
    fop(1'b0, 1'b1, 16'h20ff); chk(dev_cfg_wr_r, 1'b0);
    prog_mode <= 1'b1;
    fop(1'b1, 1'b0, 16'h20ff); chk(data_port_r, 8'h3c);
    fop(1'b0, 1'b1, 16'h20ff); chk({dev_cfg_wr_r, dev_cfg_wdata_r}, 9'h196);
    prog_mode <= 1'b0;
    cfg_byte <= 8'h80;
    fop(1'b1, 1'b0, 16'h1234); chk(data_port_r, 8'h5a);
    fop(1'b0, 1'b1, 16'h1234); chk(flash_wr_ok_r, 1'b0);
    cfg_byte <= 8'h00;
    $display("flash lock test done");
    pfc(1'b1, 1'b1);
    below_2v7 <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({core_freeze_r, core_run_r}, 2'h2);
    @(posedge clk);
    below_2v7 <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk({core_freeze_r, core_run_r}, 2'h1);
    pfc(1'b1, 1'b0);
    below_2v7 <= 1'b1;
    boot;
    chk(power_fail_detect_enable, 1'b0);
    repeat (6) @(posedge clk);
    #1 chk(core_run_r, 1'b1);
    @(posedge clk);
    below_2v7 <= 1'b0;
    $display("power-fail test done");
    cfg_byte <= 8'h02;
    pfc(1'b1, 1'b1);
    below_2v7 <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({fail_level_r, core_freeze_r}, 3'h4);
    @(posedge clk);
    below_3v0 <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({core_freeze_r, power_fail_flag_r}, 2'h3);
    @(posedge clk);
    below_3v0 <= 1'b0;
    cfg_byte <= 8'h01;
    repeat (8) @(posedge clk);
    #1 chk({core_freeze_r, core_run_r, fail_level_r}, 4'h5);
    @(posedge clk);
    below_2v4 <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk({core_freeze_r, core_run_r}, 2'h2);
    $display("threshold test done");
    conclude;
  end
  initial begin
    #(2000 * 100);
    num_errors++;
    conclude;
  end
endmodule
bind reset_and_power_fail_control rst_pwr_props #(
  .STRETCH_CYCLES(STRETCH_CYCLES)) props (.clk, .rst_b, .wdt_timeout,
  .addr_fail_en, .fetch_valid, .fetch_bad_region, .fetch_in_ram, .prog_mode,
  .flash_rd, .flash_wr, .flash_addr, .cfg_byte, .sys_reset, .core_run_r,
  .core_freeze_r, .vec_fetch_addr_r, .vec_fetch_r, .ram_page_select_r,
  .direct_page_flag_r, .main_clk_sel_r, .periph_clk_en_r,
  .power_fail_detect_enable, .power_fail_action_select, .data_port_r,
  .flash_wr_ok_r);
